// ===== common/mads_regs.vh
// Notes on behaviour
// - modulator sampling clock is master clock divided by four, all three channels.
// - each modulator delivers one bit per sampling-clock period into its filter.
// - low-pass decimation averages modulator bits into 24-bit words.
// - current channels give signed 24-bit samples at 6.99 kSPS, B identical to A.
// - full-scale current input at gain 2 reaches about plus/minus 6,500,000 codes.
// - voltage channel gives signed 24-bit samples at 6.99 kSPS.
// - full-scale voltage input at gain 1 reaches about plus/minus 6,500,000 codes.
// - channel A and channel B current samples scaled by their own gain registers.
// - offset filters on after reset; clearing setup bit 2 bypasses all three.
// - both current-channel integrators are bypassed after reset.
// - setup bit 0 inserts the integrator into the channel A current path.
// - setup bit 1 inserts the integrator into the channel B current path.
// - primary voltage gain scales the voltage samples on sampleV.
// - each gain register answers at its 0x2xx index and an alias 0x3xx index.
// - internal reference after reset; reference select bit 0 picks external one.
`ifndef MADS_REGS_VH
`define MADS_REGS_VH

// register indices; byte address is four times the index
`define MADS_IDX_SETUP      12'h102
`define MADS_IDX_AIGN       12'h280
`define MADS_IDX_PVGN       12'h281
`define MADS_IDX_BIGN       12'h28c
`define MADS_IDX_BVGN       12'h28d
`define MADS_IDX_ALIAS_BIT  8
`define MADS_IDX_VSRC       12'h800
`define MADS_IDX_SMPA       12'h020
`define MADS_IDX_SMPB       12'h021
`define MADS_IDX_SMPV       12'h022
`define MADS_IDX_SMPCNT     12'h023

// setup fields
`define MADS_SETUP_INTA     0
`define MADS_SETUP_INTB     1
`define MADS_SETUP_HPF      2
`define MADS_VSRC_EXT       0

// reset values
`define MADS_SETUP_RST      16'h0004
`define MADS_GAIN_RST       24'h400000
`define MADS_VSRC_RST       8'h00

// timing and arithmetic
`define MADS_SAMP_DIV       4
`define MADS_DECIM          128
`define MADS_GAIN_FRAC      22
`define MADS_HPF_SHIFT      8
`define MADS_INT_LEAK       6
`define MADS_INT_SCALE      3
`define MADS_CIC_GAIN_SHIFT 2

`endif

// ===== hw/mads_signal_path.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mads_regs.vh"

module mads_signal_path #(
   parameter DIV     = `MADS_SAMP_DIV,
   parameter DECIM   = `MADS_DECIM,
   parameter HPF_SH  = `MADS_HPF_SHIFT
) (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        modBitA,
   input  wire        modBitB,
   input  wire        modBitV,
   output wire        modSampleClk,
   output wire        modSampleEn,
   output wire        useExtRef,
   output wire [23:0] sampleA,
   output wire [23:0] sampleB,
   output wire [23:0] sampleV,
   output wire [23:0] sampleVb,
   output wire        sampleValid,
   input  wire [13:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [13:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);

   localparam [1:0] RESP_OKAY   = 2'b00;
   localparam [1:0] RESP_SLVERR = 2'b10;

   // saturate a wide signed value into 24 bits
   function [23:0] sat24;
      input signed [47:0] v;
      begin
         if (v > 48'sh00000007fffff)
            sat24 = 24'h7fffff;
         else if (v < -48'sh00000007fffff)
            sat24 = 24'h800001;
         else
            sat24 = v[23:0];
      end
   endfunction

   // gain word is signed with 22 fraction bits, so 0x400000 is unity
   function [23:0] applyGain;
      input [23:0] smp;
      input [23:0] gain;
      reg signed [47:0] prod;
      begin
         prod = $signed(smp) * $signed(gain);
         applyGain = sat24(prod >>> `MADS_GAIN_FRAC);
      end
   endfunction

   // gain registers live at base index and the alias one page up
   function [11:0] baseIdx;
      input [11:0] idx;
      begin
         if (idx[11:8] == 4'h3)
            baseIdx = {4'h2, idx[7:0]};
         else
            baseIdx = idx;
      end
   endfunction

   function [23:0] mergeStrb;
      input [23:0] old;
      input [23:0] dat;
      input [2:0]  strb;
      integer      k;
      begin
         mergeStrb = old;
         for (k = 0; k < 3; k = k + 1) begin
            if (strb[k])
               mergeStrb[k*8 +: 8] = dat[k*8 +: 8];
         end
      end
   endfunction

   // reset release through two flops
   reg rstMeta_r;
   reg rstSync_r;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end
   wire rstN = rstSync_r;

   reg [7:0] divCnt_r;
   reg       sampEn_r;
   reg       sampClk_r;
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         divCnt_r  <= 8'h00;
         sampEn_r  <= 1'b0;
         sampClk_r <= 1'b0;
      end else begin
         sampEn_r <= (divCnt_r == DIV - 1);
         if (divCnt_r == DIV - 1)
            divCnt_r <= 8'h00;
         else
            divCnt_r <= divCnt_r + 8'h01;
         sampClk_r <= (divCnt_r < DIV / 2);
      end
   end
   assign modSampleEn  = sampEn_r;
   assign modSampleClk = sampClk_r;

   // modulator bits cross in from the analog side
   reg [2:0] bitMeta_r;
   reg [2:0] bitSync_r;
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         bitMeta_r <= 3'b000;
         bitSync_r <= 3'b000;
      end else begin
         bitMeta_r <= {modBitV, modBitB, modBitA};
         bitSync_r <= bitMeta_r;
      end
   end

   reg [7:0] decCnt_r;
   reg [1:0] stb_r;
   wire      decimEn = sampEn_r && (decCnt_r == DECIM - 1);
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         decCnt_r <= 8'h00;
         stb_r    <= 2'b00;
      end else begin
         stb_r <= {stb_r[0], decimEn};
         if (sampEn_r) begin
            if (decCnt_r == DECIM - 1)
               decCnt_r <= 8'h00;
            else
               decCnt_r <= decCnt_r + 8'h01;
         end
      end
   end

   // register file state
   reg [15:0] setup_r;
   reg [23:0] gainAi_r;
   reg [23:0] gainPv_r;
   reg [23:0] gainBi_r;
   reg [23:0] gainBv_r;
   reg [7:0]  vsrc_r;
   wire hpfOn = setup_r[`MADS_SETUP_HPF];
   wire [2:0] intOn = {1'b0, setup_r[`MADS_SETUP_INTB:`MADS_SETUP_INTA]};

   wire [23:0] fltOut [0:2];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : chan
         reg  [23:0] i1_r;
         reg  [23:0] i2_r;
         reg  [23:0] i3_r;
         reg  [23:0] d1_r;
         reg  [23:0] d2_r;
         reg  [23:0] d3_r;
         reg  [23:0] cic_r;
         reg  [31:0] dcAcc_r;
         reg  [31:0] intAcc_r;
         reg  [23:0] flt_r;
         wire [23:0] c1 = i3_r - d1_r;
         wire [23:0] c2 = c1 - d2_r;
         wire [23:0] c3 = c2 - d3_r;
         wire signed [47:0] cicScaled = $signed(c3) <<< `MADS_CIC_GAIN_SHIFT;
         wire signed [31:0] dcEst  = $signed(dcAcc_r) >>> HPF_SH;
         wire signed [31:0] hpfDif = $signed({{8{cic_r[23]}}, cic_r}) - dcEst;
         wire [23:0] hpfY = hpfOn ? sat24({{16{hpfDif[31]}}, hpfDif}) : cic_r;
         wire signed [31:0] intNxt = $signed(intAcc_r) + $signed({{8{hpfY[23]}}, hpfY})
                                     - ($signed(intAcc_r) >>> `MADS_INT_LEAK);
         wire signed [31:0] intOut = $signed(intAcc_r) >>> `MADS_INT_SCALE;
         always @(posedge clk_sys or negedge rstN) begin
            if (!rstN) begin
               i1_r     <= 24'h000000;
               i2_r     <= 24'h000000;
               i3_r     <= 24'h000000;
               d1_r     <= 24'h000000;
               d2_r     <= 24'h000000;
               d3_r     <= 24'h000000;
               cic_r    <= 24'h000000;
               dcAcc_r  <= 32'h00000000;
               intAcc_r <= 32'h00000000;
               flt_r    <= 24'h000000;
            end else begin
               // one bit per sampling period, +1 or -1
               if (sampEn_r) begin
                  i1_r <= i1_r + (bitSync_r[g] ? 24'h000001 : 24'hffffff);
                  i2_r <= i2_r + i1_r;
                  i3_r <= i3_r + i2_r;
               end
               if (decimEn) begin
                  d1_r  <= i3_r;
                  d2_r  <= c1;
                  d3_r  <= c2;
                  cic_r <= sat24(cicScaled);
               end
               if (stb_r[0]) begin
                  dcAcc_r <= dcAcc_r + hpfDif;
                  flt_r   <= hpfY;
                  if (g < 2) begin
                     intAcc_r <= intNxt;
                     // integrator stays out unless its bit is set
                     if (intOn[g])
                        flt_r <= sat24({{16{intOut[31]}}, intOut});
                  end
               end
            end
         end
         assign fltOut[g] = flt_r;
      end
   endgenerate

   // gain stage and aligned output
   reg [23:0] smpA_r;
   reg [23:0] smpB_r;
   reg [23:0] smpV_r;
   reg [23:0] smpVb_r;
   reg        valid_r;
   reg [31:0] smpCnt_r;
   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         smpA_r   <= 24'h000000;
         smpB_r   <= 24'h000000;
         smpV_r   <= 24'h000000;
         smpVb_r  <= 24'h000000;
         valid_r  <= 1'b0;
         smpCnt_r <= 32'h00000000;
      end else begin
         valid_r <= stb_r[1];
         if (stb_r[1]) begin
            smpA_r   <= applyGain(fltOut[0], gainAi_r);
            smpB_r   <= applyGain(fltOut[1], gainBi_r);
            smpV_r   <= applyGain(fltOut[2], gainPv_r);
            smpVb_r  <= applyGain(fltOut[2], gainBv_r);
            smpCnt_r <= smpCnt_r + 32'h00000001;
         end
      end
   end
   assign sampleA     = smpA_r;
   assign sampleB     = smpB_r;
   assign sampleV     = smpV_r;
   assign sampleVb    = smpVb_r;
   assign sampleValid = valid_r;
   assign useExtRef   = vsrc_r[`MADS_VSRC_EXT];

   // AXI4-Lite write side: address and data taken in either order
   reg        awHeld_r;
   reg        wHeld_r;
   reg [11:0] awIdx_r;
   reg [31:0] wData_r;
   reg [3:0]  wStrb_r;
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   wire       awTake = s_axi_awvalid && !awHeld_r && !bvalid_r;
   wire       wTake  = s_axi_wvalid && !wHeld_r && !bvalid_r;
   wire       doWrite = awHeld_r && wHeld_r;
   wire [11:0] wBase = baseIdx(awIdx_r);
   wire        wGain = (wBase == `MADS_IDX_AIGN) || (wBase == `MADS_IDX_PVGN) ||
                       (wBase == `MADS_IDX_BIGN) || (wBase == `MADS_IDX_BVGN);
   wire        wOk   = (awIdx_r == `MADS_IDX_SETUP) || (awIdx_r == `MADS_IDX_VSRC) || wGain;

   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awIdx_r  <= 12'h000;
         wData_r  <= 32'h00000000;
         wStrb_r  <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
         setup_r  <= `MADS_SETUP_RST;
         gainAi_r <= `MADS_GAIN_RST;
         gainPv_r <= `MADS_GAIN_RST;
         gainBi_r <= `MADS_GAIN_RST;
         gainBv_r <= `MADS_GAIN_RST;
         vsrc_r   <= `MADS_VSRC_RST;
      end else begin
         if (awTake) begin
            awHeld_r <= 1'b1;
            awIdx_r  <= s_axi_awaddr[13:2];
         end
         if (wTake) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wOk ? RESP_OKAY : RESP_SLVERR;
            // setup register steers filters and integrators
            if (awIdx_r == `MADS_IDX_SETUP)
               setup_r <= {wStrb_r[1] ? wData_r[15:8] : setup_r[15:8], wStrb_r[0] ? wData_r[7:0] : setup_r[7:0]};
            if (awIdx_r == `MADS_IDX_VSRC)
               vsrc_r <= wStrb_r[0] ? wData_r[7:0] : vsrc_r;
            // gain words written as scale factors
            if (wBase == `MADS_IDX_AIGN)
               gainAi_r <= mergeStrb(gainAi_r, wData_r[23:0], wStrb_r[2:0]);
            if (wBase == `MADS_IDX_PVGN)
               gainPv_r <= mergeStrb(gainPv_r, wData_r[23:0], wStrb_r[2:0]);
            if (wBase == `MADS_IDX_BIGN)
               gainBi_r <= mergeStrb(gainBi_r, wData_r[23:0], wStrb_r[2:0]);
            if (wBase == `MADS_IDX_BVGN)
               gainBv_r <= mergeStrb(gainBv_r, wData_r[23:0], wStrb_r[2:0]);
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !awHeld_r && !bvalid_r;
   assign s_axi_wready  = !wHeld_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // AXI4-Lite read side, one cycle to answer
   reg        rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0]  rresp_r;
   reg [31:0] rdNxt;
   reg        rdOk;
   wire [11:0] rIdx  = s_axi_araddr[13:2];
   wire [11:0] rBase = baseIdx(rIdx);
   always @* begin
      rdNxt = 32'h00000000;
      rdOk  = 1'b1;
      if (rIdx == `MADS_IDX_SETUP)
         rdNxt = {16'h0000, setup_r};
      else if (rIdx == `MADS_IDX_VSRC)
         rdNxt = {24'h000000, vsrc_r};
      else if (rIdx == `MADS_IDX_SMPA)
         rdNxt = {8'h00, smpA_r};
      else if (rIdx == `MADS_IDX_SMPB)
         rdNxt = {8'h00, smpB_r};
      else if (rIdx == `MADS_IDX_SMPV)
         rdNxt = {8'h00, smpV_r};
      else if (rIdx == `MADS_IDX_SMPCNT)
         rdNxt = smpCnt_r;
      else if (rBase == `MADS_IDX_AIGN)
         rdNxt = {8'h00, gainAi_r};
      else if (rBase == `MADS_IDX_PVGN)
         rdNxt = {8'h00, gainPv_r};
      else if (rBase == `MADS_IDX_BIGN)
         rdNxt = {8'h00, gainBi_r};
      else if (rBase == `MADS_IDX_BVGN)
         rdNxt = {8'h00, gainBv_r};
      else
         rdOk = 1'b0;
   end

   always @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdNxt;
            rresp_r  <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

endmodule

// ===== test/mads_modulator_model.sv
`timescale 1ns/10ps
module mads_modulator_model (
   input  wire       rst_n,
   input  wire       modSampleClk,
   input  wire [7:0] level,
   output reg        modBitA,
   output reg        modBitB,
   output reg        modBitV
);
   reg [7:0] acc_r;
   wire [8:0] sum = {1'b0, acc_r} + {1'b0, level};
   // one bit per sampling period, all three on the same clock
   always @(posedge modSampleClk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 8'h00;
         {modBitA, modBitB, modBitV} <= 3'b000;
      end else begin
         acc_r <= sum[7:0];
         {modBitA, modBitB, modBitV} <= {3{sum[8]}};
      end
   end
endmodule

// ===== test/mads_signal_path_asserts.sv
`timescale 1ns/10ps
module mads_signal_path_asserts #(
   parameter DIV   = 4,
   parameter DECIM = 128
) (
   input wire        clk_sys,
   input wire        rst_n,
   input wire        modSampleClk,
   input wire        modSampleEn,
   input wire        useExtRef,
   input wire [23:0] sampleA,
   input wire [23:0] sampleB,
   input wire [23:0] sampleV,
   input wire [23:0] sampleVb,
   input wire        sampleValid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp
);
   localparam int PER = DIV * DECIM;
   reg [15:0] gapCnt_r;
   reg        seenValid_r;
   // first strobe after reset has no predecessor to measure from
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gapCnt_r    <= 16'h0000;
         seenValid_r <= 1'b0;
      end else begin
         gapCnt_r    <= sampleValid ? 16'h0000 : gapCnt_r + 16'h0001;
         seenValid_r <= seenValid_r | sampleValid;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_clk_high; modSampleClk [*2]; endsequence
   sequence s_clk_low; !modSampleClk [*2]; endsequence
   property p_clk_shape; $rose(modSampleClk) |-> s_clk_high ##1 s_clk_low ##1 modSampleClk; endproperty
   property p_en_period; modSampleEn |=> !modSampleEn [*3] ##1 modSampleEn; endproperty
   property p_valid_gap; sampleValid && seenValid_r |-> gapCnt_r == PER - 1; endproperty
   property p_valid_pulse; sampleValid |=> !sampleValid; endproperty
   property p_hold;
      !sampleValid |-> $stable(sampleA) && $stable(sampleB) && $stable(sampleV) && $stable(sampleVb);
   endproperty
   property p_ref_write; $changed(useExtRef) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_clk_shape: assert property (p_clk_shape) else $error("sample clock not 2 high 2 low");
   a_en_period: assert property (p_en_period) else $error("sample enable not every 4 cycles");
   a_valid_gap: assert property (p_valid_gap) else $error("sample strobe spacing wrong");
   a_valid_pulse: assert property (p_valid_pulse) else $error("sample strobe longer than one cycle");
   a_hold: assert property (p_hold) else $error("samples changed without strobe");
   a_ref_write: assert property (p_ref_write) else $error("reference select changed without write");
   a_r_done: assert property (p_r_done) else $error("read answer not withdrawn after handshake");
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
endmodule

// ===== test/mads_signal_path_bench.sv
`timescale 1ns/10ps
`include "mads_regs.vh"
module mads_signal_path_bench;
   localparam DIV   = 4;
   localparam DECIM = 8;
   reg         clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [13:0] s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata, rd;
   reg  [3:0]  s_axi_wstrb;
   reg  [7:0]  level;
   reg  [1:0]  rsp;
   reg  [23:0] snap;
   wire        modBitA, modBitB, modBitV, modSampleClk, modSampleEn, useExtRef, sampleValid;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [23:0] sampleA, sampleB, sampleV, sampleVb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer     mismatches, checked, i;
   mads_signal_path #(.DIV(DIV), .DECIM(DECIM)) dut (.clk_sys, .rst_n, .modBitA, .modBitB, .modBitV,
      .modSampleClk, .modSampleEn, .useExtRef, .sampleA, .sampleB, .sampleV, .sampleVb, .sampleValid,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   mads_modulator_model u_mod (.rst_n, .modSampleClk, .level, .modBitA, .modBitB, .modBitV);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task check(input [31:0] seen, input [31:0] exp, input string what);
      checked = checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task axi_wr(input [11:0] idx, input [31:0] d);
      reg done;
      begin
         done = 1'b0;
         @(posedge clk_sys);
         s_axi_awaddr <= {idx, 2'b00};
         s_axi_wdata <= d;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
         while (!done) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
               rsp = s_axi_bresp;
               done = 1'b1;
            end
         end
         s_axi_bready <= 1'b0;
      end
   endtask
   task axi_rd(input [11:0] idx);
      reg done;
      begin
         done = 1'b0;
         @(posedge clk_sys);
         s_axi_araddr <= {idx, 2'b00};
         {s_axi_arvalid, s_axi_rready} <= 2'b11;
         while (!done) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
               rd = s_axi_rdata;
               rsp = s_axi_rresp;
               done = 1'b1;
            end
         end
         s_axi_rready <= 1'b0;
      end
   endtask
   // bounded wait for n sample strobes
   task wait_smp(input integer n);
      integer k;
      repeat (n) begin
         k = 0;
         @(posedge clk_sys);
         while (sampleValid !== 1'b1 && k < 2000) begin
            @(posedge clk_sys);
            k = k + 1;
         end
      end
   endtask
   initial begin
      repeat (40000) @(posedge clk_sys);
      mismatches = mismatches + 1;
      tally_and_finish;
   end
   initial begin
      {mismatches, checked} = 0;
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hf;
      // quarter density: constant nonzero level after decimation
      level = 8'h40;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      axi_rd(`MADS_IDX_SETUP); check(rd, 32'h00000004, "setup reset");
      axi_rd(`MADS_IDX_AIGN); check(rd, 32'h00400000, "a gain reset");
      axi_rd(`MADS_IDX_PVGN | 12'h100); check(rd, 32'h00400000, "v gain alias reset");
      axi_rd(`MADS_IDX_VSRC); check(rd, 32'h00000000, "ref select reset");
      check(useExtRef, 1'b0, "ref pin reset");
      wait_smp(4);
      check(sampleA === sampleB, 1'b1, "a b paths equal");
      check(sampleV === sampleVb, 1'b1, "v copies equal");
      snap = sampleA;
      wait_smp(1);
      check(sampleA !== snap, 1'b1, "offset filter active");
      axi_wr(`MADS_IDX_SETUP, 32'h0); check(rsp, 2'b00, "setup write");
      wait_smp(6);
      snap = sampleA;
      wait_smp(1);
      check(sampleA === snap, 1'b1, "offset filter bypassed");
      for (i = 1; i < 3; i = i + 1) begin
         axi_wr(`MADS_IDX_SETUP, i);
         wait_smp(6);
         check(sampleA !== sampleB, 1'b1, "integrator inserted");
      end
      axi_wr(`MADS_IDX_SETUP, 32'h0);
      axi_wr(`MADS_IDX_BIGN | 12'h100, 32'h0);
      axi_rd(`MADS_IDX_BIGN); check(rd, 32'h0, "b gain via alias");
      wait_smp(4);
      check(sampleB, 24'h000000, "b gain zero");
      check(sampleA !== 24'h000000, 1'b1, "a gain unity");
      axi_rd(`MADS_IDX_SMPA); check(rd, {8'h00, sampleA}, "a sample register");
      axi_rd(`MADS_IDX_SMPB); check(rd, 32'h0, "b sample register");
      axi_rd(`MADS_IDX_SMPV); check(rd, {8'h00, sampleV}, "v sample register");
      axi_rd(`MADS_IDX_SMPCNT);
      snap = rd[23:0];
      wait_smp(1);
      axi_rd(`MADS_IDX_SMPCNT); check(rd - snap, 32'h1, "sample count step");
      axi_wr(`MADS_IDX_BVGN, 32'h0);
      wait_smp(4);
      check(sampleVb, 24'h000000, "b voltage gain zero");
      check(sampleV !== 24'h000000, 1'b1, "primary voltage gain kept");
      // primary gain given the same value as the channel b copy
      axi_wr(`MADS_IDX_PVGN | 12'h100, 32'h0);
      wait_smp(4);
      check(sampleV, 24'h000000, "primary voltage gain zero");
      axi_wr(`MADS_IDX_VSRC, 32'h1);
      repeat (2) @(posedge clk_sys);
      check(useExtRef, 1'b1, "external reference");
      axi_rd(12'h7ff); check(rsp, 2'b10, "unmapped read resp");
      check(rd, 32'h0, "unmapped read data");
      axi_wr(12'h7ff, 32'h1); check(rsp, 2'b10, "unmapped write resp");
      // leave the offset filters on and the integrators off
      axi_wr(`MADS_IDX_SETUP, 32'h4);
      tally_and_finish;
   end
endmodule
bind mads_signal_path mads_signal_path_asserts #(.DIV(DIV), .DECIM(DECIM)) u_chk (.clk_sys, .rst_n,
   .modSampleClk, .modSampleEn, .useExtRef, .sampleA, .sampleB, .sampleV, .sampleVb, .sampleValid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
